// ==== logic/sgsr_pkg.sv ====
/*
 Package for the status group and service request block: register widths,
 status byte bit positions, command codes and packed carriers.
 Assumes a command decoder upstream that turns bus text into these codes.
*/
package sgsr_pkg;
	localparam int GRP_W = 16;
	localparam int STB_W = 8;
	// Status byte bit positions
	localparam int STB_HW1 = 0;
	localparam int STB_HW2 = 1;
	localparam int STB_UNUSED = 2;
	localparam int STB_QUES = 3;
	localparam int STB_MAV = 4;
	localparam int STB_ESB = 5;
	localparam int STB_RQS = 6;
	localparam int STB_OPER = 7;
	// Link fault condition bit positions
	localparam int LF_RX = 0;
	localparam int LF_TX = 1;
	localparam logic [15:0] GRP_RESET = 16'h0000;
	localparam logic [15:0] PTR_RESET = 16'hffff;
	localparam logic [7:0] SRE_RESET = 8'h00;
	localparam logic [7:0] SRE_WMASK = 8'hbf;
	// Register selector within a group
	typedef enum logic [2:0] {
		SGSR_SEL_COND = 3'b000,
		SGSR_SEL_PTR = 3'b001,
		SGSR_SEL_NTR = 3'b010,
		SGSR_SEL_EVENT = 3'b011,
		SGSR_SEL_ENABLE = 3'b100
	} sgsr_sel_t;
	// Group selector
	typedef enum logic [1:0] {
		SGSR_GRP_HW1 = 2'b00,
		SGSR_GRP_LINK = 2'b01,
		SGSR_GRP_STB = 2'b10,
		SGSR_GRP_SRE = 2'b11
	} sgsr_grp_t;
	// One decoded access from the controller
	typedef struct packed {
		logic valid;
		logic write;
		sgsr_grp_t grp;
		sgsr_sel_t sel;
		logic [15:0] data;
	} sgsr_req_t;
	// Answer to a query
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} sgsr_rsp_t;
endpackage

// ==== logic/sgsr_status.sv ====
/*
 Status group and service request logic: first hardware group, link fault
 group, status byte, service request enable and the SRQ line.
 Assumes decoded requests on core_clk; condition inputs may be asynchronous.
*/
// Behaviour
// - Event register clears when queried and on clear-status command.
// - Enable register clears only by writing zero to it.
// - Link fault group has 16-bit cond, filters, event, enable, summary.
// - Link fault bit 15 reads 0; bits 14..2 carry nothing.
// - Bit 1 shows transmit link failure, bit 0 receive link failure.
// - Link fault group: cond RO, filters RW, event RO, enable RW.
// - Hardware group offers the same access set.
// - Hardware group summary reaches status byte bit 0; link summary goes out on linkSummary_ff only.
// - Status byte bit map: 7,5,4,3,1,0 from summaries; bit 2 unused.
// - Bit 6 gives request-service on poll, master summary on query.
// - Enabled set status bit asserts SRQ and sets request-service.
// - Serial poll clears request-service until a new reason arises.
// - Service request enable is 8 bits; bit 6 of writes ignored.
`timescale 1ns/1ns
module sgsr_status #(
	parameter int GW = sgsr_pkg::GRP_W
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire sgsr_pkg::sgsr_req_t req,
	input wire logic clearStatus,
	input wire logic serialPoll,
	input wire logic [GW-1:0] hwCondIn,
	input wire logic txLinkFail,
	input wire logic rxLinkFail,
	input wire logic operSummary,
	input wire logic hw2Summary,
	input wire logic quesSummary,
	input wire logic std_event_summary_bit,
	input wire logic output_message_available,
	output sgsr_pkg::sgsr_rsp_t rsp_ff,
	output logic [7:0] pollByte_ff,
	output logic srq_ff,
	output logic linkSummary_ff
);
	localparam int NG = 2;
	// Two flops for asynchronous condition inputs; first stage feeds only second
	logic [NG-1:0][GW-1:0] condMeta_ff;
	logic [NG-1:0][GW-1:0] cond_ff;
	logic [NG-1:0][GW-1:0] condPrev_ff;
	logic [NG-1:0][GW-1:0] ptr_ff;
	logic [NG-1:0][GW-1:0] ntr_ff;
	logic [NG-1:0][GW-1:0] event_ff;
	logic [NG-1:0][GW-1:0] enable_ff;
	logic [NG-1:0][GW-1:0] rawCond;
	logic [NG-1:0] summary;
	logic [7:0] sre_ff;
	logic rqs_ff;
	logic srqPrev_ff;
	logic [7:0] stbCore;
	logic master_summary_bit;
	logic [15:0] nxt_rspData;

	// Link fault condition: only bits 1 and 0 live, rest forced low
	always_comb begin
		rawCond[0] = hwCondIn;
		rawCond[1] = '0;
		rawCond[1][sgsr_pkg::LF_TX] = txLinkFail;
		rawCond[1][sgsr_pkg::LF_RX] = rxLinkFail;
	end

	// Per-group register set, one instance of the same structure each
	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : gGroup
			logic isGrp;
			logic wrHit;
			logic evRead;
			assign isGrp = req.valid &&
				(req.grp == ((g == 0) ? sgsr_pkg::SGSR_GRP_HW1 :
				sgsr_pkg::SGSR_GRP_LINK));
			assign wrHit = isGrp && req.write;
			assign evRead = isGrp && !req.write &&
				(req.sel == sgsr_pkg::SGSR_SEL_EVENT);

			// Condition sampling, edges judged between synced samples
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					condMeta_ff[g] <= sgsr_pkg::GRP_RESET;
					cond_ff[g] <= sgsr_pkg::GRP_RESET;
					condPrev_ff[g] <= sgsr_pkg::GRP_RESET;
				end else begin
					condMeta_ff[g] <= rawCond[g];
					cond_ff[g] <= condMeta_ff[g];
					condPrev_ff[g] <= cond_ff[g];
				end
			end

			// Writable filters and enable; a zero write is the only clear
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					ptr_ff[g] <= sgsr_pkg::PTR_RESET;
					ntr_ff[g] <= sgsr_pkg::GRP_RESET;
					enable_ff[g] <= sgsr_pkg::GRP_RESET;
				end else if (wrHit) begin
					case (req.sel)
						sgsr_pkg::SGSR_SEL_PTR: ptr_ff[g] <= req.data;
						sgsr_pkg::SGSR_SEL_NTR: ntr_ff[g] <= req.data;
						sgsr_pkg::SGSR_SEL_ENABLE: enable_ff[g] <= req.data;
						default: ;
					endcase
				end
			end

			// Event latch; a new edge in the clearing cycle survives the clear
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					event_ff[g] <= sgsr_pkg::GRP_RESET;
				end else begin
					event_ff[g] <= ((evRead || clearStatus) ? '0 : event_ff[g]) |
						(cond_ff[g] & ~condPrev_ff[g] & ptr_ff[g]) |
						(~cond_ff[g] & condPrev_ff[g] & ntr_ff[g]);
				end
			end

			assign summary[g] = |(event_ff[g] & enable_ff[g]);
		end
	endgenerate

	// Status byte core, bit 6 filled in by the reader
	always_comb begin
		stbCore = '0;
		stbCore[sgsr_pkg::STB_OPER] = operSummary;
		stbCore[sgsr_pkg::STB_ESB] = std_event_summary_bit;
		stbCore[sgsr_pkg::STB_MAV] = output_message_available;
		stbCore[sgsr_pkg::STB_QUES] = quesSummary;
		stbCore[sgsr_pkg::STB_HW2] = hw2Summary;
		stbCore[sgsr_pkg::STB_HW1] = summary[0];
	end

	// Master summary: any enabled status bit, bit 6 excluded by mask
	assign master_summary_bit = |(stbCore & sre_ff);

	// Service request enable; bit 6 of written data dropped
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sre_ff <= sgsr_pkg::SRE_RESET;
		end else if (req.valid && req.write &&
			req.grp == sgsr_pkg::SGSR_GRP_SRE) begin
			sre_ff <= req.data[7:0] & sgsr_pkg::SRE_WMASK;
		end
	end

	// Request service sets on a new reason, poll clears it; set wins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rqs_ff <= 1'b0;
			srqPrev_ff <= 1'b0;
		end else begin
			srqPrev_ff <= master_summary_bit;
			if (master_summary_bit && !srqPrev_ff) begin
				rqs_ff <= 1'b1;
			end else if (serialPoll) begin
				rqs_ff <= 1'b0;
			end
		end
	end

	// SRQ line follows the pending request, dropped by the poll
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			srq_ff <= 1'b0;
		end else begin
			srq_ff <= rqs_ff && !(serialPoll && !(master_summary_bit && !srqPrev_ff));
		end
	end

	// Poll byte captured at the poll: bit 6 is request-service
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pollByte_ff <= '0;
		end else if (serialPoll) begin
			pollByte_ff <= stbCore | ({7'h00, rqs_ff} << sgsr_pkg::STB_RQS);
		end
	end

	// Query answer mux
	always_comb begin
		nxt_rspData = '0;
		case (req.grp)
			sgsr_pkg::SGSR_GRP_HW1, sgsr_pkg::SGSR_GRP_LINK: begin
				case (req.sel)
					sgsr_pkg::SGSR_SEL_COND: nxt_rspData = cond_ff[req.grp[0]];
					sgsr_pkg::SGSR_SEL_PTR: nxt_rspData = ptr_ff[req.grp[0]];
					sgsr_pkg::SGSR_SEL_NTR: nxt_rspData = ntr_ff[req.grp[0]];
					sgsr_pkg::SGSR_SEL_EVENT: nxt_rspData = event_ff[req.grp[0]];
					sgsr_pkg::SGSR_SEL_ENABLE:
						nxt_rspData = enable_ff[req.grp[0]];
					default: nxt_rspData = '0;
				endcase
			end
			// Query of the byte reports master summary in bit 6
			sgsr_pkg::SGSR_GRP_STB:
				nxt_rspData = {8'h00,
					stbCore | ({7'h00, master_summary_bit} << sgsr_pkg::STB_RQS)};
			sgsr_pkg::SGSR_GRP_SRE: nxt_rspData = {8'h00, sre_ff};
			default: nxt_rspData = '0;
		endcase
	end

	// Registered answer, one cycle after a read request
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.valid <= req.valid && !req.write;
			rsp_ff.data <= nxt_rspData;
		end
	end

	// Link group summary goes out to feed the first hardware group
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			linkSummary_ff <= 1'b0;
		end else begin
			linkSummary_ff <= summary[1];
		end
	end
endmodule // sgsr_status

// ==== verification/sgsr_status_asserts.sv ====
/*
 Port checker for sgsr_status.
 Assumes one core_clk domain; bound below.
*/
`timescale 1ns/1ns
module sgsr_status_asserts (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire sgsr_pkg::sgsr_req_t req,
	input wire logic clearStatus,
	input wire logic serialPoll,
	input wire logic txLinkFail,
	input wire logic rxLinkFail,
	input wire sgsr_pkg::sgsr_rsp_t rsp_ff,
	input wire logic srq_ff
);
	// Decoded reads; the link inputs pass a two-flop synchroniser
	wire logic rd = req.valid && !req.write;
	wire logic rdLink = rd && req.grp == sgsr_pkg::SGSR_GRP_LINK;
	wire logic rdEvt = rdLink && req.sel == sgsr_pkg::SGSR_SEL_EVENT;
	wire logic rdCond = rdLink && req.sel == sgsr_pkg::SGSR_SEL_COND;
	wire logic onSre = req.valid && req.grp == sgsr_pkg::SGSR_GRP_SRE;
	wire logic [1:0] linkIn = {txLinkFail, rxLinkFail};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_quiet;
		$stable(linkIn)[*6];
	endsequence
	sequence s_sreWrRd;
		onSre && req.write ##1 onSre && !req.write;
	endsequence
	property p_readAns;
		rd |=> rsp_ff.valid;
	endproperty
	a_readAns: assert property (p_readAns)
		else $error("read unanswered");
	property p_writeMute;
		req.valid && req.write |=> !rsp_ff.valid;
	endproperty
	a_writeMute: assert property (p_writeMute)
		else $error("write answered");
	property p_condHigh;
		rdCond |=> rsp_ff.data[15:2] == 14'h0000;
	endproperty
	a_condHigh: assert property (p_condHigh)
		else $error("unused fault bits set");
	property p_condBits;
		s_quiet ##0 rdCond |=> rsp_ff.data[1:0] == $past(linkIn);
	endproperty
	a_condBits: assert property (p_condBits)
		else $error("fault bits wrong");
	property p_sreMask;
		s_sreWrRd |=> rsp_ff.data == ($past(req.data, 2) & 16'h00bf);
	endproperty
	a_sreMask: assert property (p_sreMask)
		else $error("request enable readback wrong");
	property p_evtClr;
		s_quiet ##0 (rdEvt || clearStatus) ##1 rdEvt |=> rsp_ff.data == 16'h0000;
	endproperty
	a_evtClr: assert property (p_evtClr)
		else $error("event not cleared");
	property p_stbBits;
		rd && req.grp == sgsr_pkg::SGSR_GRP_STB
			|=> rsp_ff.data[15:8] == 8'h00 && !rsp_ff.data[2];
	endproperty
	a_stbBits: assert property (p_stbBits)
		else $error("status byte unused bit set");
	property p_srqFall;
		$fell(srq_ff) |-> $past(serialPoll);
	endproperty
	a_srqFall: assert property (p_srqFall)
		else $error("request dropped without poll");
endmodule // sgsr_status_asserts
bind sgsr_status sgsr_status_asserts u_sgsr_status_asserts (
	.core_clk(core_clk), .reset_n(reset_n), .req(req),
	.clearStatus(clearStatus), .serialPoll(serialPoll),
	.txLinkFail(txLinkFail), .rxLinkFail(rxLinkFail),
	.rsp_ff(rsp_ff), .srq_ff(srq_ff));

// ==== verification/sgsr_ctrl_model.sv ====
/*
 Bus controller model: accesses, clear-status and serial polls.
 Assumes its tasks are called one at a time.
*/
`timescale 1ns/1ns
module sgsr_ctrl_model (
	input wire logic core_clk,
	output sgsr_pkg::sgsr_req_t req,
	output logic clearStatus,
	output logic serialPoll
);
	initial begin
		req = '0;
		clearStatus = 1'b0;
		serialPoll = 1'b0;
	end
	// Strobes last one cycle: the edge that takes them drops them
	always @(posedge core_clk) begin
		req.valid <= 1'b0;
		clearStatus <= 1'b0;
		serialPoll <= 1'b0;
	end
	// Writing zero to an enable is the only way to clear it
	task automatic acc(input logic w, input logic [1:0] g,
		input logic [2:0] s, input logic [15:0] d);
		@(negedge core_clk);
		req = {1'b1, w, g, s, d};
	endtask
	task automatic cls();
		@(negedge core_clk);
		clearStatus = 1'b1;
	endtask
	task automatic poll();
		@(negedge core_clk);
		serialPoll = 1'b1;
	endtask
endmodule // sgsr_ctrl_model

// ==== verification/tb_status_group_and_service_request.sv ====
/*
 Self-checking bench for sgsr_status.
 Assumes the controller model and the bound checker.
*/
`timescale 1ns/1ns
module tb_status_group_and_service_request;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic tx = 1'b0;
	logic rx = 1'b0;
	logic outMsg = 1'b0;
	logic [15:0] hwCond = 16'h0000;
	logic [3:0] sums = 4'h0;
	sgsr_pkg::sgsr_req_t req;
	logic clearStatus;
	logic serialPoll;
	sgsr_pkg::sgsr_rsp_t rsp;
	logic [7:0] pollByte;
	logic srq;
	logic linkSum;
	logic [15:0] expQ[$];
	logic [31:0] lfsr = 32'h49c48c01;
	logic [2:0] sels [3] = '{3'h1, 3'h2, 3'h4};
	int fails = 0;
	int check_count = 0;
	always #2 core_clk = ~core_clk;
	sgsr_ctrl_model u_sgsr_ctrl_model (.core_clk(core_clk), .req(req),
		.clearStatus(clearStatus), .serialPoll(serialPoll));
	sgsr_status u_sgsr_status (.core_clk(core_clk), .reset_n(reset_n),
		.req(req), .clearStatus(clearStatus), .serialPoll(serialPoll),
		.hwCondIn(hwCond), .txLinkFail(tx), .rxLinkFail(rx),
		.operSummary(sums[3]), .hw2Summary(sums[2]),
		.quesSummary(sums[1]),
		.std_event_summary_bit(sums[0]), .output_message_available(outMsg),
		.rsp_ff(rsp), .pollByte_ff(pollByte), .srq_ff(srq),
		.linkSummary_ff(linkSum));
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Random source for stimulus: one step of the bench shift register
	function automatic logic [31:0] nextLfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// A read leaves its expected answer in the queue
	task automatic op(input logic w, input logic [1:0] g,
		input logic [2:0] s, input logic [15:0] d);
		if (!w) expQ.push_back(d);
		u_sgsr_ctrl_model.acc(w, g, s, w ? d : 16'h0000);
	endtask
	task automatic give_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Answers are matched in order; an unasked answer cannot match
	always @(negedge core_clk) begin
		if (rsp.valid === 1'b1) begin
			chk("rsp", rsp.data, expQ.size() > 0 ? expQ.pop_front() : 16'hxxxx);
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk) reset_n = 1'b1;
		op(1'b0, 2'h1, 3'h1, 16'hffff);
		for (int i = 0; i < 6; i++) begin
			lfsr = nextLfsr(lfsr);
			op(1'b1, 2'(i / 3), sels[i % 3], lfsr[15:0]);
			op(1'b0, 2'(i / 3), sels[i % 3], lfsr[15:0]);
		end
		op(1'b1, 2'h0, 3'h4, 16'h0000);
		op(1'b0, 2'h0, 3'h4, 16'h0000);
		op(1'b1, 2'h1, 3'h1, 16'hffff);
		op(1'b1, 2'h1, 3'h4, 16'h0002);
		$display("registers done");
		tx = 1'b1;
		rx = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("summary", 16'(linkSum), 16'h0001);
		op(1'b0, 2'h1, 3'h0, 16'h0003);
		op(1'b0, 2'h1, 3'h3, 16'h0003);
		op(1'b0, 2'h1, 3'h3, 16'h0000);
		rx = 1'b0;
		repeat (6) @(negedge core_clk);
		rx = 1'b1;
		repeat (8) @(negedge core_clk);
		u_sgsr_ctrl_model.cls();
		op(1'b0, 2'h1, 3'h3, 16'h0000);
		hwCond = 16'h0010;
		repeat (6) @(negedge core_clk);
		op(1'b0, 2'h0, 3'h0, 16'h0010);
		$display("link faults done");
		op(1'b1, 2'h3, 3'h0, 16'h00ff);
		op(1'b0, 2'h3, 3'h0, 16'h00bf);
		outMsg = 1'b1;
		repeat (8) @(negedge core_clk);
		chk("srq", 16'(srq), 16'h0001);
		op(1'b0, 2'h2, 3'h0, 16'h0050);
		u_sgsr_ctrl_model.poll();
		@(negedge core_clk);
		chk("poll", 16'(pollByte), 16'h0050);
		chk("srq", 16'(srq), 16'h0000);
		u_sgsr_ctrl_model.poll();
		@(negedge core_clk);
		chk("poll", 16'(pollByte), 16'h0010);
		sums = 4'hf;
		repeat (2) @(negedge core_clk);
		op(1'b0, 2'h2, 3'h0, 16'h00fa);
		repeat (2) @(negedge core_clk);
		chk("pending", 16'(expQ.size()), 16'h0000);
		$display("service request done");
		give_verdict();
	end
	// The run needs about 80 cycles; this bounds a hang
	initial begin
		#20000;
		fails++;
		give_verdict();
	end
endmodule // tb_status_group_and_service_request
